// file: common/nvc_pkg.sv
// constants for the host-side controller of the nonvolatile static memory
package nvc_pkg;
   // memory geometry
   localparam int unsigned NVC_ADDR_W = 13;
   localparam int unsigned NVC_DATA_W = 8;

   // software request address sequence
   localparam logic [12:0] NVC_SEQ_A0        = 13'h0000;
   localparam logic [12:0] NVC_SEQ_A1        = 13'h1555;
   localparam logic [12:0] NVC_SEQ_A2        = 13'h0AAA;
   localparam logic [12:0] NVC_SEQ_A3        = 13'h1FFF;
   localparam logic [12:0] NVC_SEQ_A4        = 13'h10F0;
   localparam logic [12:0] NVC_SEQ_STORE_A5  = 13'h0F0F;
   localparam logic [12:0] NVC_SEQ_RECALL_A5 = 13'h0F0E;
   localparam logic [2:0]  NVC_SEQ_LEN       = 3'h6;

   // clock rate and timing
   localparam int unsigned NVC_CLK_MHZ         = 200;
   localparam int unsigned NVC_STORE_TIME_MS   = 10;
   localparam int unsigned NVC_RECALL_TIME_US  = 20;
   localparam int unsigned NVC_RESTORE_TIME_US = 550;
   localparam int unsigned NVC_STORE_CYC       = NVC_STORE_TIME_MS * 1000 * NVC_CLK_MHZ;
   localparam int unsigned NVC_RECALL_CYC      = NVC_RECALL_TIME_US * NVC_CLK_MHZ;
   localparam int unsigned NVC_RESTORE_CYC     = NVC_RESTORE_TIME_US * NVC_CLK_MHZ;
   // bus phase lengths in clocks: setup, strobe, recovery
   localparam logic [3:0]  NVC_PH_SETUP  = 4'h1;
   localparam logic [3:0]  NVC_PH_STROBE = 4'h8;
   localparam logic [3:0]  NVC_PH_HOLD   = 4'h2;

   // host commands
   typedef enum logic [1:0]
   {
      NVC_CMD_READ   = 2'b00,
      NVC_CMD_WRITE  = 2'b01,
      NVC_CMD_STORE  = 2'b10,
      NVC_CMD_RECALL = 2'b11
   } nvc_cmd_e;
endpackage

// file: design/nvc_wait_timer.sv
// down-counting wait timer used for nonvolatile busy windows
`timescale 1ns/1ps
module nvc_wait_timer #(
   parameter int unsigned CNT_W = 24
)
(
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // control
   input  wire logic             i_load,
   input  wire logic [CNT_W-1:0] i_count,
   // status
   output logic                  o_done
);
   logic [CNT_W-1:0] cnt_r;

   ////////////////////////////////////////////////////////////////////////////
   // load wins over counting so a restart is never missed
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         cnt_r <= '0;
      else if (i_load)
         cnt_r <= i_count;
      else if (cnt_r != '0)
         cnt_r <= cnt_r - 1'b1;
   end

   assign o_done = (cnt_r == '0) && !i_load;
endmodule

// file: design/nvc_host_ctrl.sv
// host controller that drives the nonvolatile static memory through its pins
// Function
// - address stable across whole write
// - drive pin kept high during writes
// - store sequence: six select-controlled reads
// - recall sequence ends at 0F0E
// - strobe high through all six reads
`timescale 1ns/1ps
module nvc_host_ctrl
   import nvc_pkg::*;
#(
   parameter int unsigned STORE_CYC   = NVC_STORE_CYC,
   parameter int unsigned RECALL_CYC  = NVC_RECALL_CYC,
   parameter int unsigned RESTORE_CYC = NVC_RESTORE_CYC
)
(
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   // user command port
   input  wire logic                  i_req_valid,
   output logic                       o_req_ready,
   input  wire logic [1:0]            i_req_cmd,
   input  wire logic [NVC_ADDR_W-1:0] i_req_addr,
   input  wire logic [NVC_DATA_W-1:0] i_req_wdata,
   input  wire logic                  i_hw_store_req,
   output logic                       o_rsp_valid,
   output logic [NVC_DATA_W-1:0]      o_rsp_rdata,
   output logic                       o_nv_busy,
   output logic                       o_written,
   // memory pins
   output logic [NVC_ADDR_W-1:0]      o_addr,
   output logic                       o_cs_n,
   output logic                       o_load_strobe_n,
   output logic                       o_output_drive_n,
   input  wire logic [NVC_DATA_W-1:0] i_data_pins,
   output logic [NVC_DATA_W-1:0]      o_data_pins,
   output logic                       o_data_pins_oe,
   input  wire logic                  i_hw_store_busy_n,
   output logic                       o_hw_store_busy_n,
   output logic                       o_hw_store_busy_oe
);
   localparam int unsigned TW = 32;

   typedef enum logic [2:0]
   {
      NVC_ST_POWERUP = 3'b000,
      NVC_ST_IDLE    = 3'b001,
      NVC_ST_SETUP   = 3'b010,
      NVC_ST_STROBE  = 3'b011,
      NVC_ST_HOLD    = 3'b100,
      NVC_ST_NVWAIT  = 3'b101,
      NVC_ST_BUSYHI  = 3'b110
   } nvc_state_e;

   nvc_state_e            state_r;
   nvc_cmd_e              cmd_r;
   logic [NVC_ADDR_W-1:0] addr_r;
   logic [NVC_DATA_W-1:0] wdata_r;
   logic [NVC_DATA_W-1:0] rdata_r;
   logic                  rsp_r;
   logic [3:0]            ph_r;
   logic [2:0]            seq_r;
   logic                  written_r;
   logic                  hwst_r;
   logic                  timer_load;
   logic [TW-1:0]         timer_count;
   logic                  timer_done;
   logic                  is_seq;
   logic                  take;

   ////////////////////////////////////////////////////////////////////////////
   // step address of a software request; last step depends on the command
   function automatic logic [NVC_ADDR_W-1:0] seq_addr(input logic [2:0] idx,
                                                      input nvc_cmd_e cmd);
      case (idx)
         3'h0:    seq_addr = NVC_SEQ_A0;
         3'h1:    seq_addr = NVC_SEQ_A1;
         3'h2:    seq_addr = NVC_SEQ_A2;
         3'h3:    seq_addr = NVC_SEQ_A3;
         3'h4:    seq_addr = NVC_SEQ_A4;
         default: seq_addr = (cmd == NVC_CMD_STORE) ? NVC_SEQ_STORE_A5 : NVC_SEQ_RECALL_A5;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // command acceptance
   assign is_seq      = (cmd_r == NVC_CMD_STORE) || (cmd_r == NVC_CMD_RECALL);
   // writes are refused while the device holds the busy pin low
   assign o_req_ready = (state_r == NVC_ST_IDLE) && i_hw_store_busy_n && !hwst_r;
   assign take        = o_req_ready && i_req_valid;
   assign o_nv_busy   = (state_r == NVC_ST_NVWAIT) || (state_r == NVC_ST_BUSYHI)
                        || (state_r == NVC_ST_POWERUP);
   assign o_written   = written_r;

   ////////////////////////////////////////////////////////////////////////////
   // main sequencer
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state_r <= NVC_ST_POWERUP;
         cmd_r   <= NVC_CMD_READ;
         addr_r  <= '0;
         wdata_r <= '0;
         ph_r    <= 4'h0;
         seq_r   <= 3'h0;
      end
      else
      begin
         case (state_r)
            NVC_ST_POWERUP:
               if (timer_done)
                  state_r <= NVC_ST_IDLE;
            NVC_ST_IDLE:
               if (take)
               begin
                  cmd_r   <= nvc_cmd_e'(i_req_cmd);
                  addr_r  <= i_req_addr;
                  wdata_r <= i_req_wdata;
                  seq_r   <= 3'h0;
                  ph_r    <= NVC_PH_SETUP;
                  state_r <= NVC_ST_SETUP;
               end
            NVC_ST_SETUP:
               // address settles before select falls
               if (ph_r == 4'h1)
               begin
                  ph_r    <= NVC_PH_STROBE;
                  state_r <= NVC_ST_STROBE;
               end
               else
                  ph_r <= ph_r - 4'h1;
            NVC_ST_STROBE:
               if (ph_r == 4'h1)
               begin
                  ph_r    <= NVC_PH_HOLD;
                  state_r <= NVC_ST_HOLD;
               end
               else
                  ph_r <= ph_r - 4'h1;
            NVC_ST_HOLD:
               // select high between cycles: exactly one fall per access
               if (ph_r != 4'h1)
                  ph_r <= ph_r - 4'h1;
               else if (is_seq && (seq_r != NVC_SEQ_LEN - 3'h1))
               begin
                  // back-to-back sequence reads, nothing else interleaved
                  seq_r   <= seq_r + 3'h1;
                  ph_r    <= NVC_PH_SETUP;
                  state_r <= NVC_ST_SETUP;
               end
               else if (is_seq)
                  state_r <= NVC_ST_NVWAIT;
               else
                  state_r <= NVC_ST_IDLE;
            NVC_ST_NVWAIT:
               // device erases and programs, or clears and reloads, meanwhile
               if (timer_done)
                  state_r <= NVC_ST_BUSYHI;
            NVC_ST_BUSYHI:
               if (i_hw_store_busy_n)
                  state_r <= NVC_ST_IDLE;
            default:
               state_r <= NVC_ST_IDLE;
         endcase
         // a power-fail or pin store seen in idle parks the host
         if (state_r == NVC_ST_IDLE && !take && (!i_hw_store_busy_n || hwst_r))
            state_r <= NVC_ST_BUSYHI;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // host-driven store request on the busy pin, only if something changed
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         hwst_r <= 1'b0;
      else if (state_r == NVC_ST_BUSYHI && !i_hw_store_busy_n)
         hwst_r <= 1'b0;
      else if (i_hw_store_req && written_r && state_r == NVC_ST_IDLE)
         hwst_r <= 1'b1;
   end

   assign o_hw_store_busy_n  = 1'b0;
   assign o_hw_store_busy_oe = hwst_r;

   ////////////////////////////////////////////////////////////////////////////
   // written flag: set by a finished write, cleared by finished software transfer or by busy pin low in NVC_ST_BUSYHI
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         written_r <= 1'b0;
      else if (state_r == NVC_ST_HOLD && cmd_r == NVC_CMD_WRITE && ph_r == NVC_PH_HOLD)
         written_r <= 1'b1;
      else if ((state_r == NVC_ST_NVWAIT && timer_done)
               || (state_r == NVC_ST_BUSYHI && !i_hw_store_busy_n))
         written_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive; write keeps drive pin high, sequence reads never strobe
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_addr           <= '0;
         o_cs_n           <= 1'b1;
         o_load_strobe_n  <= 1'b1;
         o_output_drive_n <= 1'b1;
         o_data_pins      <= '0;
         o_data_pins_oe   <= 1'b0;
      end
      else
      begin
         // address held constant from setup to end of hold
         o_addr <= is_seq ? seq_addr(seq_r, cmd_r) : addr_r;
         o_cs_n <= !(state_r == NVC_ST_STROBE);
         o_load_strobe_n  <= !(state_r == NVC_ST_STROBE && cmd_r == NVC_CMD_WRITE);
         // drive pin left high for sequence reads, data is of no use
         o_output_drive_n <= !(state_r == NVC_ST_STROBE && cmd_r == NVC_CMD_READ);
         o_data_pins      <= wdata_r;
         o_data_pins_oe   <= (state_r != NVC_ST_IDLE) && (cmd_r == NVC_CMD_WRITE)
                             && (state_r == NVC_ST_SETUP || state_r == NVC_ST_STROBE
                                 || state_r == NVC_ST_HOLD);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read capture at end of strobe; one-cycle answer
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         rdata_r <= '0;
         rsp_r   <= 1'b0;
      end
      else
      begin
         rsp_r <= 1'b0;
         if (state_r == NVC_ST_STROBE && ph_r == 4'h1 && cmd_r == NVC_CMD_READ)
            rdata_r <= i_data_pins;
         if (state_r == NVC_ST_HOLD && ph_r == 4'h1 && !is_seq)
            rsp_r <= 1'b1;
         else if (state_r == NVC_ST_NVWAIT && timer_done)
            rsp_r <= 1'b1;
      end
   end

   assign o_rsp_valid = rsp_r;
   assign o_rsp_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // busy windows: power-up recall, store, recall (software store unconditional)
   always_comb
   begin
      timer_load  = 1'b0;
      timer_count = TW'(STORE_CYC);
      if (state_r == NVC_ST_HOLD && ph_r == 4'h1 && is_seq && seq_r == NVC_SEQ_LEN - 3'h1)
      begin
         timer_load  = 1'b1;
         timer_count = (cmd_r == NVC_CMD_STORE) ? TW'(STORE_CYC) : TW'(RECALL_CYC);
      end
      else if (i_rst)
      begin
         timer_load  = 1'b1;
         timer_count = TW'(RESTORE_CYC);
      end
   end

   // recalls are never limited: each just reloads the timer
   nvc_wait_timer #(
      .CNT_W (TW)
   ) u_timer (
      .i_clk   (i_clk),
      .i_rst   (1'b0),
      .i_load  (timer_load),
      .i_count (timer_count),
      .o_done  (timer_done)
   );
endmodule

// file: verification/nvc_host_ctrl_assertions.sv
// pin and status assertions for the host controller
`timescale 1ns/1ps
module nvc_host_ctrl_chk
(
   // clock and reset
   input wire logic        i_clk,
   input wire logic        i_rst,
   // watched ports
   input wire logic        o_req_ready,
   input wire logic        o_nv_busy,
   input wire logic        o_written,
   input wire logic [12:0] o_addr,
   input wire logic        o_cs_n,
   input wire logic        o_load_strobe_n,
   input wire logic        o_output_drive_n,
   input wire logic        o_data_pins_oe,
   input wire logic        i_hw_store_busy_n,
   input wire logic        o_hw_store_busy_oe
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // one access keeps select low for the strobe phase, then a gap
   sequence s_sel_low;
      !o_cs_n [*8] ##1 o_cs_n;
   endsequence
   sequence s_sel_gap;
      o_cs_n [*2];
   endsequence
   // reset must park the pins; own disable since reset is the cause
   chk_idle_reset: assert property (disable iff (1'b0) i_rst |=> o_cs_n && o_load_strobe_n
      && o_output_drive_n && !o_data_pins_oe) else $error("pins not idle after reset");
   chk_select_once: assert property ($fell(o_cs_n) |-> s_sel_low)
      else $error("select low window wrong");
   chk_select_gap: assert property ($rose(o_cs_n) |-> s_sel_gap)
      else $error("select gap too short");
   chk_addr_stable: assert property (!o_cs_n && !$fell(o_cs_n) |-> $stable(o_addr))
      else $error("address moved during access");
   chk_write_drive: assert property (!o_load_strobe_n |-> !o_cs_n && o_output_drive_n
      && o_data_pins_oe) else $error("write without select or with drive");
   chk_read_drive: assert property (!o_output_drive_n |-> o_load_strobe_n
      && !o_data_pins_oe) else $error("read with strobe or own drive");
   chk_busy_ready: assert property (!i_hw_store_busy_n |-> !o_req_ready)
      else $error("ready while busy pin low");
   chk_nv_ready: assert property (o_nv_busy |-> !o_req_ready)
      else $error("ready during transfer");
   chk_pull_cond: assert property ($rose(o_hw_store_busy_oe) |-> $past(o_written))
      else $error("busy pull without prior write");
endmodule
bind nvc_host_ctrl nvc_host_ctrl_chk i_chk (
   .i_clk              (i_clk),
   .i_rst              (i_rst),
   .o_req_ready        (o_req_ready),
   .o_nv_busy          (o_nv_busy),
   .o_written          (o_written),
   .o_addr             (o_addr),
   .o_cs_n             (o_cs_n),
   .o_load_strobe_n    (o_load_strobe_n),
   .o_output_drive_n   (o_output_drive_n),
   .o_data_pins_oe     (o_data_pins_oe),
   .i_hw_store_busy_n  (i_hw_store_busy_n),
   .o_hw_store_busy_oe (o_hw_store_busy_oe)
);

// file: verification/nvc_dev_model.sv
// behavioural model of the nonvolatile static memory on the far side
`timescale 1ns/1ps
module nvc_dev_model
   import nvc_pkg::*;
#(
   parameter int unsigned ST_CYC = 40,
   parameter int unsigned RC_CYC = 15
)
(
   // clock and pins
   input  wire logic        i_clk,
   input  wire logic [12:0] i_addr,
   input  wire logic        i_cs_n,
   input  wire logic        i_load_strobe_n,
   input  wire logic        i_output_drive_n,
   input  wire logic        i_hw_store_busy_n,
   input  wire logic        i_power_fail,
   input  wire logic [7:0]  i_dq,
   output logic [7:0]       o_dq,
   output logic             o_dq_en,
   output logic             o_busy_pull
);
   logic [7:0]  sram [8192];
   logic [7:0]  nv [8192];
   logic [12:0] seq [5] = '{NVC_SEQ_A0, NVC_SEQ_A1, NVC_SEQ_A2, NVC_SEQ_A3, NVC_SEQ_A4};
   logic        cs_q = 1'b1;
   logic        wr_flag = 1'b0;
   int          idx = 0;
   int          tmr = RC_CYC;
   initial o_busy_pull = 1'b0;
   // drive only in a plain read with no transfer running
   assign o_dq_en = tmr == 0 && !i_cs_n && !i_output_drive_n && i_load_strobe_n
      && i_hw_store_busy_n;
   assign o_dq = sram[i_addr];
   // transfers, sequence detection and writes
   always @(posedge i_clk)
   begin
      cs_q <= i_cs_n;
      if (tmr > 0)
      begin
         tmr <= tmr - 1;
         if (tmr == 1) o_busy_pull <= 1'b0;
      end
      // supply drop or busy pin: conditional store, writes held off meanwhile
      else if (!i_hw_store_busy_n || i_power_fail)
      begin
         idx <= 0;
         if (wr_flag)
         begin
            foreach (nv[i]) nv[i] = 8'hFF;
            foreach (nv[i]) nv[i] = sram[i];
            o_busy_pull <= 1'b1;
            tmr <= ST_CYC;
            wr_flag <= 1'b0;
         end
      end
      else
      begin
         if (!i_cs_n && !i_load_strobe_n)
         begin
            sram[i_addr] = i_dq;
            wr_flag <= 1'b1;
         end
         // sequence steps on select fall only, drive pin ignored
         if (cs_q && !i_cs_n)
         begin
            if (!i_load_strobe_n) idx <= 0;
            else if (idx == 5 && i_addr == NVC_SEQ_STORE_A5)
            begin
               foreach (nv[i]) nv[i] = 8'hFF;
               foreach (nv[i]) nv[i] = sram[i];
               o_busy_pull <= 1'b1;
               tmr <= ST_CYC;
               wr_flag <= 1'b0;
               idx <= 0;
            end
            else if (idx == 5 && i_addr == NVC_SEQ_RECALL_A5)
            begin
               foreach (sram[i]) sram[i] = 8'h00;
               foreach (sram[i]) sram[i] = nv[i];
               tmr <= RC_CYC;
               wr_flag <= 1'b0;
               idx <= 0;
            end
            else if (idx < 5 && i_addr == seq[idx]) idx <= idx + 1;
            else idx <= (i_addr == NVC_SEQ_A0) ? 1 : 0;
         end
      end
   end
endmodule

// file: verification/nvc_host_ctrl_tb_top.sv
// self-checking bench for the host controller against the memory model
`timescale 1ns/1ps
module nvc_host_ctrl_tb_top;
   typedef struct { logic [1:0] cmd; logic [12:0] a; logic [7:0] d; } nvc_row_s;
   logic        clk = 0, rst = 1, vld = 0, hreq = 0, pf = 0;
   logic [1:0]  cmd = 2'h0;
   logic [12:0] addr = 13'h0000, p_addr;
   logic [7:0]  wd = 8'h00, p_dq, h_dq, d_dq, rd, bus_last = 8'h00;
   logic        rdy, rsp, nvb, wrt, cs_n, ls_n, od_n, h_oe, d_en, b_oe, b_n, pull;
   wire  [7:0]  bus = h_oe ? h_dq : (d_en ? d_dq : ~bus_last);
   wire         busy_w = !(b_oe && !b_n) && !pull;
   int          miscompares = 0, checks_done = 0;
   nvc_row_s    rows [6] = '{'{2'h1, 13'h0000, 8'h5A}, '{2'h1, 13'h1FFF, 8'hA5},
      '{2'h0, 13'h0000, 8'h5A}, '{2'h0, 13'h1FFF, 8'hA5}, '{2'h1, 13'h1FFF, 8'h00},
      '{2'h0, 13'h1FFF, 8'h00}};
   always #2.5 clk = ~clk;
   // released bus shows the inverse of its last level
   always @(posedge clk) bus_last <= bus;
   nvc_host_ctrl #(.STORE_CYC(50), .RECALL_CYC(20), .RESTORE_CYC(30)) i_dut (.i_clk(clk),
      .i_rst(rst), .i_req_valid(vld), .o_req_ready(rdy), .i_req_cmd(cmd), .i_req_addr(addr),
      .i_req_wdata(wd), .i_hw_store_req(hreq), .o_rsp_valid(rsp), .o_rsp_rdata(rd),
      .o_nv_busy(nvb), .o_written(wrt), .o_addr(p_addr), .o_cs_n(cs_n),
      .o_load_strobe_n(ls_n), .o_output_drive_n(od_n), .i_data_pins(bus), .o_data_pins(h_dq),
      .o_data_pins_oe(h_oe), .i_hw_store_busy_n(busy_w), .o_hw_store_busy_n(b_n),
      .o_hw_store_busy_oe(b_oe));
   nvc_dev_model i_dev (.i_clk(clk), .i_addr(p_addr), .i_cs_n(cs_n), .i_load_strobe_n(ls_n),
      .i_output_drive_n(od_n), .i_hw_store_busy_n(busy_w), .i_power_fail(pf), .i_dq(bus), .o_dq(d_dq),
      .o_dq_en(d_en), .o_busy_pull(pull));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // bounded wait at falling edges: 0 ready, 1 response, 2 busy pull
   task automatic wait_until(input int sel);
      int n;
      for (n = 0; n < 4000; n++)
      begin
         if ((sel == 0 && rdy === 1'b1) || (sel == 1 && rsp === 1'b1)
            || (sel == 2 && b_oe === 1'b1)) break;
         @(negedge clk);
      end
      if (n == 4000)
      begin
         $display("wait %0d ran out", sel);
         miscompares++;
         results();
      end
   endtask
   task automatic do_cmd(input logic [1:0] c, input logic [12:0] a, input logic [7:0] d);
      wait_until(0);
      cmd = c;
      addr = a;
      wd = d;
      vld = 1'b1;
      @(negedge clk);
      vld = 1'b0;
      wait_until(1);
   endtask
   // reset, table of plain accesses, then transfers and busy pin cases
   initial
   begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check({cs_n, ls_n, od_n, rdy, nvb}, 16'h001D);
      $display("test reset done");
      foreach (rows[i])
      begin
         do_cmd(rows[i].cmd, rows[i].a, rows[i].d);
         if (rows[i].cmd == 2'h0) check(rd, rows[i].d);
         else check(wrt, 1'b1);
      end
      $display("test table done");
      do_cmd(2'h1, 13'h0100, 8'hC3);
      do_cmd(2'h2, 13'h0000, 8'h00);
      check(wrt, 1'b0);
      do_cmd(2'h1, 13'h0100, 8'h3C);
      repeat (2) do_cmd(2'h3, 13'h0000, 8'h00);
      do_cmd(2'h0, 13'h0100, 8'h00);
      check(rd, 8'hC3);
      do_cmd(2'h2, 13'h0000, 8'h00);
      $display("test store recall done");
      @(negedge clk);
      hreq = 1'b1;
      repeat (20) @(negedge clk);
      check(b_oe, 1'b0);
      hreq = 1'b0;
      do_cmd(2'h1, 13'h0200, 8'h96);
      hreq = 1'b1;
      wait_until(2);
      check(b_oe, 1'b1);
      @(negedge clk);
      hreq = 1'b0;
      check(rdy, 1'b0);
      wait_until(0);
      check(wrt, 1'b0);
      do_cmd(2'h1, 13'h0200, 8'h00);
      do_cmd(2'h3, 13'h0000, 8'h00);
      do_cmd(2'h0, 13'h0200, 8'h00);
      check(rd, 8'h96);
      $display("test busy pin done");
      // supply drop after a fresh write: conditional store, host parks
      do_cmd(2'h1, 13'h0300, 8'h69);
      pf = 1'b1;
      @(negedge clk);
      pf = 1'b0;
      @(negedge clk);
      check({nvb, rdy}, 16'h0002);
      wait_until(0);
      check(wrt, 1'b0);
      do_cmd(2'h1, 13'h0300, 8'h00);
      do_cmd(2'h3, 13'h0000, 8'h00);
      do_cmd(2'h0, 13'h0300, 8'h00);
      check(rd, 8'h69);
      $display("test power fail done");
      results();
   end
endmodule
